// [design/dram_command_input_interface.sv]
// Purpose: Samples the memory command pins, decodes commands, tracks power states.
// Assumes: Memory clock is far slower than i_ref_clk and is sampled as a level.
// Notes:   Outputs describe what the device core should do; no data path here.
`timescale 1ns/100ps
`default_nettype none
module dram_command_input_interface
  import dram_cmd_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_clock_true,
  input  wire logic              i_clock_complement,
  input  wire logic              i_clock_gate,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_row_strobe_n,
  input  wire logic              i_col_strobe_n,
  input  wire logic              i_write_strobe_n,
  input  wire logic              i_termination_enable,
  input  wire logic [BANK_W-1:0] i_bank_select,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_mode_reg_one_term_on,
  input  wire logic              i_mode_reg_two_term_on,
  input  wire logic              i_case_hot,
  output logic                   o_cmd_valid,
  output cmd_t                   o_cmd,
  output logic      [BANK_W-1:0] o_bank,
  output logic      [ADDR_W-1:0] o_row,
  output logic      [COL_W-1:0]  o_col,
  output logic                   o_auto_precharge,
  output logic                   o_precharge_all,
  output logic                   o_burst_chop,
  output power_t                 o_power_state,
  output logic                   o_clocks_on,
  output logic                   o_input_buffers_on,
  output logic                   o_output_drivers_on,
  output logic                   o_termination_on,
  output logic      [BANKS-1:0]  o_open_banks,
  output logic                   o_timing_ready,
  output logic                   o_ext_temp_sr_ok
);

  logic [PIN_W-1:0]  pins_s;
  logic              ck_s;
  logic              ckn_s;
  logic              cke_s;
  logic              cs_n_s;
  logic              odt_s;
  logic [2:0]        strobes_s;
  logic [BANK_W-1:0] bank_s;
  logic [ADDR_W-1:0] addr_s;

  dram_pin_sync #(.W(PIN_W)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       ({i_clock_true, i_clock_complement, i_clock_gate, i_chip_select_n,
                 i_row_strobe_n, i_col_strobe_n, i_write_strobe_n,
                 i_termination_enable, i_bank_select, i_addr}),
    .o_q       (pins_s)
  );

  assign {ck_s, ckn_s, cke_s, cs_n_s, strobes_s, odt_s, bank_s, addr_s} = pins_s;

  logic              ck_d_r;
  logic              cke_prev_r;
  logic              cke_prev_nxt;
  power_t            state_r;
  power_t            state_nxt;
  logic [BANKS-1:0]  open_r;
  logic [BANKS-1:0]  open_nxt;
  logic              valid_r;
  logic              valid_nxt;
  cmd_t              cmd_r;
  cmd_t              cmd_nxt;
  logic [BANK_W-1:0] bank_r;
  logic [BANK_W-1:0] bank_nxt;
  logic [ADDR_W-1:0] row_r;
  logic [ADDR_W-1:0] row_nxt;
  logic              ap_r;
  logic              ap_nxt;
  logic              all_r;
  logic              all_nxt;
  logic              chop_r;
  logic              chop_nxt;
  logic              term_r;
  logic              term_nxt;
  logic [3:0]        wait_r;
  logic [3:0]        wait_nxt;
  logic              mr2_auto_r;
  logic              mr2_auto_nxt;
  logic              mr2_ext_r;
  logic              mr2_ext_nxt;

  logic              edge_w;
  logic              take_w;
  logic              sr_entry_w;
  logic              pd_entry_w;
  cmd_t              cmd_in_w;
  logic              is_rw_w;

  assign edge_w   = ck_s && !ck_d_r && !ckn_s;
  assign cmd_in_w = cmd_t'(strobes_s);
  assign is_rw_w  = (cmd_in_w == CMD_READ) || (cmd_in_w == CMD_WRITE);
  assign take_w   = edge_w && (state_r == PS_RUN) && cke_s && cke_prev_r && !cs_n_s;
  assign pd_entry_w = edge_w && (state_r == PS_RUN) && cke_prev_r && !cke_s;
  assign sr_entry_w = pd_entry_w && !cs_n_s && (cmd_in_w == CMD_REFRESH);

  always_comb begin
    cke_prev_nxt = edge_w ? cke_s : cke_prev_r;
    state_nxt    = state_r;
    unique case (state_r)
      PS_RUN: begin
        if (sr_entry_w) begin
          state_nxt = PS_SELF_REF;
        end else if (pd_entry_w) begin
          state_nxt = (|open_r) ? PS_ACT_PD : PS_PRE_PD;
        end
      end
      PS_PRE_PD, PS_ACT_PD: begin
        if (edge_w && cke_s) begin
          state_nxt = PS_RUN;
        end
      end
      PS_SELF_REF: begin
        if (cke_s) begin
          state_nxt = PS_RUN;
        end
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      always_comb begin
        open_nxt[g] = open_r[g];
        if (take_w && (bank_s == BANK_W'(g))) begin
          if (cmd_in_w == CMD_ACTIVATE) begin
            open_nxt[g] = 1'b1;
          end else if (is_rw_w && addr_s[PRECHARGE_BIT]) begin
            open_nxt[g] = 1'b0;
          end
        end
        if (take_w && (cmd_in_w == CMD_PRECHARGE) &&
            (addr_s[PRECHARGE_BIT] || (bank_s == BANK_W'(g)))) begin
          open_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    valid_nxt    = take_w;
    cmd_nxt      = cmd_r;
    bank_nxt     = bank_r;
    row_nxt      = row_r;
    ap_nxt       = ap_r;
    all_nxt      = all_r;
    chop_nxt     = chop_r;
    mr2_auto_nxt = mr2_auto_r;
    mr2_ext_nxt  = mr2_ext_r;
    wait_nxt     = (wait_r != WAIT_RESET) ? wait_r - 4'h1 : wait_r;
    if (take_w) begin
      cmd_nxt  = cmd_in_w;
      // bank or register select, address use
      bank_nxt = bank_s;
      row_nxt  = addr_s;
      ap_nxt   = is_rw_w && addr_s[PRECHARGE_BIT];
      all_nxt  = (cmd_in_w == CMD_PRECHARGE) && addr_s[PRECHARGE_BIT];
      chop_nxt = is_rw_w && !addr_s[CHOP_BIT];
      unique case (cmd_in_w)
        CMD_ACTIVATE:  wait_nxt = ACT_TO_COL_CYC;
        CMD_PRECHARGE: wait_nxt = PRECHARGE_CYC;
        CMD_READ:      wait_nxt = READ_LATENCY_CYC;
        default:       wait_nxt = wait_nxt;
      endcase
      if ((cmd_in_w == CMD_MODE_SET) && (bank_s == MODE_REG_TWO_SEL)) begin
        mr2_auto_nxt = addr_s[MR2_AUTO_SR_BIT];
        mr2_ext_nxt  = addr_s[MR2_EXT_SR_BIT];
      end
    end
  end

  // termination follows pin, ignored when off or self-refreshing
  always_comb begin
    term_nxt = term_r;
    if (state_r == PS_SELF_REF || sr_entry_w) begin
      term_nxt = 1'b0;
    end else if (edge_w) begin
      term_nxt = odt_s && (i_mode_reg_one_term_on || i_mode_reg_two_term_on);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ck_d_r     <= 1'b0;
      cke_prev_r <= 1'b0;
      state_r    <= PS_RUN;
      open_r     <= '0;
      valid_r    <= 1'b0;
      cmd_r      <= CMD_NOP;
      bank_r     <= '0;
      row_r      <= '0;
      ap_r       <= 1'b0;
      all_r      <= 1'b0;
      chop_r     <= 1'b0;
      term_r     <= 1'b0;
      wait_r     <= WAIT_RESET;
      mr2_auto_r <= 1'b0;
      mr2_ext_r  <= 1'b0;
    end else begin
      ck_d_r     <= ck_s;
      cke_prev_r <= cke_prev_nxt;
      state_r    <= state_nxt;
      open_r     <= open_nxt;
      valid_r    <= valid_nxt;
      cmd_r      <= cmd_nxt;
      bank_r     <= bank_nxt;
      row_r      <= row_nxt;
      ap_r       <= ap_nxt;
      all_r      <= all_nxt;
      chop_r     <= chop_nxt;
      term_r     <= term_nxt;
      wait_r     <= wait_nxt;
      mr2_auto_r <= mr2_auto_nxt;
      mr2_ext_r  <= mr2_ext_nxt;
    end
  end

  assign o_cmd_valid         = valid_r;
  assign o_cmd               = cmd_r;
  assign o_bank              = bank_r;
  assign o_row               = row_r;
  assign o_col               = row_r[COL_W-1:0];
  assign o_auto_precharge    = ap_r;
  assign o_precharge_all     = all_r;
  assign o_burst_chop        = chop_r;
  assign o_power_state       = state_r;
  assign o_clocks_on         = (state_r == PS_RUN);
  assign o_output_drivers_on = (state_r == PS_RUN);
  // command and address buffers off in low power
  assign o_input_buffers_on  = (state_r == PS_RUN);
  assign o_termination_on    = term_r;
  assign o_open_banks        = open_r;
  assign o_timing_ready      = (wait_r == WAIT_RESET);
  // hot case flagged; the refresh rate itself is the controller's job
  assign o_ext_temp_sr_ok    = !i_case_hot || mr2_auto_r || mr2_ext_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence idle_gate_drop_s;
    pd_entry_w && !sr_entry_w && !(|open_r);
  endsequence

  sequence open_gate_drop_s;
    pd_entry_w && !sr_entry_w && (|open_r);
  endsequence

  a_cs_masks_cmd: assert property (edge_w && cs_n_s |=> !valid_r)
    else $error("command taken while chip select high");
  a_cmd_decode: assert property (valid_r |-> cmd_r == $past(cmd_in_w) && $past(edge_w))
    else $error("decoded command does not match sampled strobes");
  a_edge_only: assert property (!edge_w |=> !valid_r)
    else $error("command taken without clock crossing");
  a_pd_idle_entry: assert property (idle_gate_drop_s |=> state_r == PS_PRE_PD)
    else $error("idle power-down not entered");
  a_pd_open_entry: assert property (open_gate_drop_s |=> state_r == PS_ACT_PD)
    else $error("active power-down not entered");
  a_sr_exit_async: assert property (state_r == PS_SELF_REF && cke_s |=> state_r == PS_RUN)
    else $error("self-refresh exit not taken on gate rise");
  a_sr_no_term: assert property (state_r == PS_SELF_REF |-> !term_r ##1 !valid_r)
    else $error("termination or command active in self-refresh");
  a_term_follows: assert property (edge_w && state_r == PS_RUN && !sr_entry_w |=>
                                   term_r == $past(odt_s && (i_mode_reg_one_term_on ||
                                   i_mode_reg_two_term_on)))
    else $error("termination does not follow registered enable");
  a_lowpower_quiet: assert property (state_r != PS_RUN |=> !valid_r)
    else $error("command decoded in low-power state");
  a_chop_polarity: assert property (valid_r && (cmd_r == CMD_READ || cmd_r == CMD_WRITE) |->
                                    chop_r == !$past(addr_s[CHOP_BIT]))
    else $error("burst chop polarity wrong");
  a_ap_closes_bank: assert property (take_w && is_rw_w && addr_s[PRECHARGE_BIT] |=>
                                     !open_r[$past(bank_s)])
    else $error("auto-precharge left bank open");
  a_act_wait: assert property (take_w && cmd_in_w == CMD_ACTIVATE |=>
                               wait_r == ACT_TO_COL_CYC ##1 o_timing_ready)
    else $error("activate to column window wrong");

endmodule : dram_command_input_interface
`default_nettype wire

// [common/dram_cmd_pkg.sv]
// Purpose: Shared constants and types for the DRAM command input interface.
// Assumes: One 10 MHz core clock; the memory clock pins are sampled, not used as clocks.
// Notes:   Commands are coded as {row strobe, column strobe, write strobe} with select low.
package dram_cmd_pkg;

  localparam int          CLK_PERIOD_PS           = 100000;
  localparam int          READ_LATENCY_TIME_PS    = 13125;
  localparam int          ACT_TO_COL_TIME_PS      = 13125;
  localparam int          PRECHARGE_PERIOD_PS     = 13125;
  localparam logic [3:0]  READ_LATENCY_CYC        =
    4'((READ_LATENCY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0]  ACT_TO_COL_CYC          =
    4'((ACT_TO_COL_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0]  PRECHARGE_CYC           =
    4'((PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam int          BANKS                   = 8;
  localparam int          BANK_W                  = 3;
  localparam int          ADDR_W                  = 15;
  localparam int          COL_W                   = 10;
  localparam int          PIN_W                   = 8 + BANK_W + ADDR_W;
  localparam int          PRECHARGE_BIT           = 10;
  localparam int          CHOP_BIT                = 12;
  localparam int          MR2_AUTO_SR_BIT         = 6;
  localparam int          MR2_EXT_SR_BIT          = 7;
  localparam logic [2:0]  MODE_REG_TWO_SEL        = 3'h2;
  localparam logic [3:0]  WAIT_RESET              = 4'h0;

  typedef enum logic [2:0] {
    CMD_MODE_SET  = 3'h0,
    CMD_REFRESH   = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE  = 3'h3,
    CMD_WRITE     = 3'h4,
    CMD_READ      = 3'h5,
    CMD_CALIBRATE = 3'h6,
    CMD_NOP       = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    PS_RUN      = 2'h0,
    PS_PRE_PD   = 2'h1,
    PS_ACT_PD   = 2'h2,
    PS_SELF_REF = 2'h3
  } power_t;

endpackage : dram_cmd_pkg

// [design/dram_pin_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level; no word coherence is promised.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module dram_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule : dram_pin_sync
`default_nettype wire

// [verif/dram_ctrl_model.sv]
// Purpose: Memory controller model that drives the command pins of the device.
// Assumes: The memory clock runs only while a command slot is issued, then stands still.
// Notes:   Unselected slots invert bank and address so stale values never pass as fresh.
`timescale 1ns/100ps
`default_nettype none
module dram_ctrl_model
  import dram_cmd_pkg::*;
(
  input  wire logic              i_ref_clk,
  output logic                   o_clock_true,
  output logic                   o_clock_complement,
  output logic                   o_clock_gate,
  output logic                   o_chip_select_n,
  output logic [2:0]             o_strobes_n,
  output logic [BANK_W-1:0]      o_bank_select,
  output logic [ADDR_W-1:0]      o_addr
);
  initial begin
    o_clock_true       = 1'b0;
    o_clock_complement = 1'b1;
    o_clock_gate       = 1'b0;
    o_chip_select_n    = 1'b1;
    o_strobes_n        = 3'h7;
    o_bank_select      = '0;
    o_addr             = '0;
  end

  task automatic issue(input logic cs_n, input logic [2:0] code,
                       input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr,
                       input logic gate);
    @(negedge i_ref_clk);
    o_clock_true       = 1'b0;
    o_clock_complement = 1'b1;
    o_clock_gate       = gate | (~cs_n & code[2] & ~code[1]);
    o_chip_select_n    = cs_n;
    o_strobes_n        = code;
    o_bank_select      = cs_n ? ~o_bank_select : bank;
    o_addr             = cs_n ? ~o_addr : addr;
    // Pins stay put four cycles either side of the rise
    repeat (4) @(negedge i_ref_clk);
    o_clock_true       = 1'b1;
    o_clock_complement = 1'b0;
    repeat (4) @(negedge i_ref_clk);
  endtask : issue

  task automatic set_gate(input logic gate);
    @(negedge i_ref_clk);
    o_clock_gate = gate;
  endtask : set_gate
endmodule : dram_ctrl_model
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench for the command input interface.
// Assumes: The controller model paces commands at one per memory clock.
// Notes:   Expected commands queue up; a negedge monitor pops one per valid pulse.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) chk((a) !== (b), 32'(a), 32'(b))
module testbench
  import dram_cmd_pkg::*;
;
  typedef struct packed {
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } note_t;

  logic              i_ref_clk, i_resetn, i_termination_enable, i_case_hot;
  logic              i_mode_reg_one_term_on, i_mode_reg_two_term_on;
  logic              clk_t, clk_c, gate, cs_n;
  logic [2:0]        strb_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic              o_cmd_valid, o_auto_precharge, o_precharge_all, o_burst_chop;
  logic              o_clocks_on, o_input_buffers_on, o_output_drivers_on;
  logic              o_termination_on, o_timing_ready, o_ext_temp_sr_ok;
  cmd_t              o_cmd;
  power_t            o_power_state;
  logic [BANK_W-1:0] o_bank;
  logic [ADDR_W-1:0] o_row;
  logic [COL_W-1:0]  o_col;
  logic [BANKS-1:0]  o_open_banks;
  int                n_mismatch, checked, n_lo, exp_lo;
  logic [31:0]       seed;
  logic [BANK_W-1:0] bk;
  logic [ADDR_W-1:0] ad;
  note_t             notes[$];
  note_t             e;

  dram_ctrl_model i_dram_ctrl_model (
    .i_ref_clk(i_ref_clk), .o_clock_true(clk_t), .o_clock_complement(clk_c),
    .o_clock_gate(gate), .o_chip_select_n(cs_n), .o_strobes_n(strb_n),
    .o_bank_select(bank), .o_addr(addr));

  dram_command_input_interface i_dram_command_input_interface (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clock_true(clk_t),
    .i_clock_complement(clk_c), .i_clock_gate(gate), .i_chip_select_n(cs_n),
    .i_row_strobe_n(strb_n[2]), .i_col_strobe_n(strb_n[1]), .i_write_strobe_n(strb_n[0]),
    .i_termination_enable(i_termination_enable), .i_bank_select(bank), .i_addr(addr),
    .i_mode_reg_one_term_on(i_mode_reg_one_term_on),
    .i_mode_reg_two_term_on(i_mode_reg_two_term_on), .i_case_hot(i_case_hot),
    .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_bank(o_bank), .o_row(o_row),
    .o_col(o_col), .o_auto_precharge(o_auto_precharge), .o_precharge_all(o_precharge_all),
    .o_burst_chop(o_burst_chop), .o_power_state(o_power_state), .o_clocks_on(o_clocks_on),
    .o_input_buffers_on(o_input_buffers_on), .o_output_drivers_on(o_output_drivers_on),
    .o_termination_on(o_termination_on), .o_open_banks(o_open_banks),
    .o_timing_ready(o_timing_ready), .o_ext_temp_sr_ok(o_ext_temp_sr_ok));

  task automatic chk(input bit bad, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (bad) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cmd(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    notes.push_back('{cmd_t'(c), b, a});
    // Window lengths come from the latency limits, one count per busy cycle
    if (c == CMD_ACTIVATE) begin
      exp_lo += int'(ACT_TO_COL_CYC);
    end else if (c == CMD_PRECHARGE) begin
      exp_lo += int'(PRECHARGE_CYC);
    end else if (c == CMD_READ) begin
      exp_lo += int'(READ_LATENCY_CYC);
    end
    i_dram_ctrl_model.issue(1'b0, c, b, a, 1'b1);
    repeat (2) @(negedge i_ref_clk);
  endtask : cmd

  // Unselected slot; gate low here asks for a power state
  task automatic idle(input logic g);
    i_dram_ctrl_model.issue(1'b1, 3'h7, '0, '0, g);
    repeat (2) @(negedge i_ref_clk);
  endtask : idle

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    conclude();
  end

  always @(negedge i_ref_clk) begin
    if (i_resetn === 1'b1 && o_timing_ready !== 1'b1) begin
      n_lo++;
    end
    if (i_resetn === 1'b1 && o_cmd_valid === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK(o_cmd_valid, 1'b0);
      end else begin
        e = notes.pop_front();
        `CHK(o_cmd, e.cmd);
        `CHK(o_bank, e.bank);
        `CHK(o_row, e.addr);
        if (e.cmd == CMD_READ || e.cmd == CMD_WRITE) begin
          `CHK(o_col, e.addr[COL_W-1:0]);
          `CHK(o_auto_precharge, e.addr[PRECHARGE_BIT]);
          `CHK(o_burst_chop, ~e.addr[CHOP_BIT]);
        end
        if (e.cmd == CMD_PRECHARGE) begin
          `CHK(o_precharge_all, e.addr[PRECHARGE_BIT]);
        end
      end
    end
  end

  initial begin
    seed = 32'h1d58;
    i_resetn = 1'b0;
    i_termination_enable = 1'b1;
    i_mode_reg_one_term_on = 1'b1;
    i_mode_reg_two_term_on = 1'b0;
    i_case_hot = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    `CHK(o_cmd, CMD_NOP);
    `CHK(o_clocks_on, 1'b1);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    idle(1'b1);
    `CHK(o_ext_temp_sr_ok, 1'b1);
    i_case_hot = 1'b1;
    @(negedge i_ref_clk);
    `CHK(o_ext_temp_sr_ok, 1'b0);
    // manual extended-range self-refresh, then both bits cleared
    cmd(CMD_MODE_SET, MODE_REG_TWO_SEL, 15'h0080);
    `CHK(o_ext_temp_sr_ok, 1'b1);
    cmd(CMD_MODE_SET, MODE_REG_TWO_SEL, 15'h0000);
    `CHK(o_ext_temp_sr_ok, 1'b0);
    cmd(CMD_MODE_SET, MODE_REG_TWO_SEL, 15'h0040);
    `CHK(o_ext_temp_sr_ok, 1'b1);
    `CHK(o_termination_on, 1'b1);
    // Every code once, each followed back to back by an unselected read
    for (int c = 0; c < 8; c++) begin
      // Reads and writes go to the bank just activated, so auto-precharge closes it
      if (c <= CMD_ACTIVATE) begin
        bk = BANK_W'($random(seed));
      end
      ad = ADDR_W'($random(seed));
      ad[PRECHARGE_BIT] = (c == CMD_READ);
      cmd(3'(c), bk, ad);
      if (c == CMD_ACTIVATE) begin
        `CHK(o_open_banks, 8'h1 << bk);
      end
      i_dram_ctrl_model.issue(1'b1, CMD_READ, bk, ad, 1'b1);
    end
    `CHK(o_open_banks, 8'h0);
    idle(1'b0);
    `CHK(o_power_state, PS_PRE_PD);
    `CHK(o_clocks_on, 1'b0);
    `CHK(o_input_buffers_on, 1'b0);
    `CHK(o_output_drivers_on, 1'b0);
    idle(1'b1);
    `CHK(o_power_state, PS_RUN);
    cmd(CMD_ACTIVATE, 3'h5, 15'h7abc);
    idle(1'b0);
    `CHK(o_power_state, PS_ACT_PD);
    idle(1'b1);
    cmd(CMD_PRECHARGE, 3'h5, 15'h0000);
    `CHK(o_open_banks, 8'h0);
    i_dram_ctrl_model.issue(1'b0, CMD_REFRESH, '0, '0, 1'b0);
    repeat (2) @(negedge i_ref_clk);
    `CHK(o_power_state, PS_SELF_REF);
    `CHK(o_termination_on, 1'b0);
    `CHK(o_input_buffers_on, 1'b0);
    // Memory clock stands still while the gate rises
    i_dram_ctrl_model.set_gate(1'b1);
    repeat (5) @(negedge i_ref_clk);
    `CHK(o_power_state, PS_RUN);
    idle(1'b1);
    i_mode_reg_one_term_on = 1'b0;
    idle(1'b1);
    `CHK(o_termination_on, 1'b0);
    for (int k = 0; k < 20 && notes.size() != 0; k++) begin
      @(negedge i_ref_clk);
    end
    `CHK(notes.size(), 0);
    `CHK(n_lo, exp_lo);
    conclude();
  end
endmodule : testbench
`default_nettype wire
